// *** include/lie_defs.vh ***
// constants for the load input enable sequencer
`ifndef LIE_DEFS_VH
`define LIE_DEFS_VH
// register byte offsets
`define LIE_OFF_CTRL 8'h00
`define LIE_OFF_COUPLE 8'h04
`define LIE_OFF_INHMODE 8'h08
`define LIE_OFF_FALL0 8'h0c
`define LIE_OFF_FALL1 8'h10
`define LIE_OFF_RISE0 8'h14
`define LIE_OFF_RISE1 8'h18
`define LIE_OFF_CMD 8'h1c
`define LIE_OFF_PON 8'h20
`define LIE_OFF_PAIR 8'h24
`define LIE_OFF_STATUS 8'h28
// control and command word fields
`define LIE_CTRL_WE_POS 8
`define LIE_CMD_CLR_POS 0
`define LIE_CMD_RST_POS 2
`define LIE_CMD_SAV_POS 3
`define LIE_CMD_SLOT_POS 4
// status word fields
`define LIE_ST_EN_POS 0
`define LIE_ST_PROT_POS 2
`define LIE_ST_INH_POS 4
`define LIE_ST_PEND_POS 6
// inhibit mode codes
`define LIE_INH_OFF 2'h0
`define LIE_INH_LIVE 2'h1
`define LIE_INH_LATCH 2'h2
// power-on selector: 0 defaults, 1..10 slot 0..9
`define LIE_PON_DEFAULTS 4'h0
`define LIE_PON_LAST 4'ha
`define LIE_SLOTS 10
// reset values
`define LIE_RST_STATE 2'h0
`define LIE_RST_COUPLE 2'h0
`define LIE_RST_DELAY 20'h00000
// timing: delay in ms, up to 1023 s
`define LIE_DLY_MAX 20'hf9c18
`define LIE_TICK_NS 1000000
`define LIE_CLK_NS 4
`define LIE_TICK_CYC (`LIE_TICK_NS / `LIE_CLK_NS)
`endif

// *** verilog/lie_sequencer.v ***
// two-channel input enable sequencer with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "lie_defs.vh"

// Contract
// - disabled channel drives no load enable
// - state reads 0 off, 1 on; reset off
// - coupled channels switch together, also by pins
// - single coupled set, new selection replaces
// - coupling write forces all inputs off
// - coupling survives instrument reset command
// - commanded off waits channel fall delay
// - fall delay 0 to 1023 s, reset zero
// - protection off skips fall delay
// - every off-to-on waits rise delay
// - rise delay 0 to 1023 s, 1 ms steps
// - latching inhibit holds off until cleared
// - live inhibit follows pin
// - inhibit mode off ignores pin
// - commanded-off channel untouched by inhibit
// - inhibit mode survives instrument reset
// - protection latches off until clear request
// - clear restores prior commanded state
// - power-on selector: defaults or slot; reset defaults
// - ten slots, save overwrites
module lie_sequencer #(
    parameter TICK_CYC = `LIE_TICK_CYC
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // external pins
    input wire inhibit_pin,
    input wire couple_on_pin,
    input wire couple_off_pin,
    input wire [1:0] prot_trip,
    // load side
    output reg [1:0] input_enable,
    output reg [1:0] paired_parallel_mode
);

    // address decode used by the write strobes and the error answer; the read mux decodes paddr itself
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a <= `LIE_OFF_STATUS);
        end
    endfunction

    // register state
    reg [1:0] cmd_state;
    reg [1:0] couple_set;
    reg [1:0] inh_mode;
    reg [19:0] fall_dly [0:1];
    reg [19:0] rise_dly [0:1];
    reg [3:0] pon_sel;
    reg [1:0] prot_lat;
    reg inh_lat;
    reg [1:0] pend;
    reg [31:0] tick_cnt;
    reg tick;
    // saved slots: commanded state plus valid flag
    reg [1:0] slot_state [0:`LIE_SLOTS-1];
    reg [`LIE_SLOTS-1:0] slot_valid;
    // pin synchronisers
    reg [4:0] sync_a;
    reg [4:0] sync_b;
    reg [4:0] sync_d;

    wire inh_s = sync_b[0];
    wire con_s = sync_b[1];
    wire coff_s = sync_b[2];
    wire [1:0] prot_s = sync_b[4:3];
    wire inh_rise = inh_s & ~sync_d[0];
    wire con_rise = con_s & ~sync_d[1];
    wire coff_rise = coff_s & ~sync_d[2];

    // bus strobes
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite & pready;
    wire wr_ctrl = wr & hit(paddr, `LIE_OFF_CTRL);
    wire wr_couple = wr & hit(paddr, `LIE_OFF_COUPLE);
    wire wr_cmd = wr & hit(paddr, `LIE_OFF_CMD);
    wire [1:0] clr_req = wr_cmd ? pwdata[1:0] : 2'h0;
    wire soft_rst = wr_cmd & pwdata[`LIE_CMD_RST_POS];
    wire save_req = wr_cmd & pwdata[`LIE_CMD_SAV_POS];
    wire [3:0] save_slot = pwdata[7:4];
    wire [1:0] wdat = pwdata[1:0];
    wire [1:0] wen = pwdata[`LIE_CTRL_WE_POS+1:`LIE_CTRL_WE_POS];

    // clamp a written delay to the 1023 s ceiling
    function [19:0] clamp;
        input [31:0] v;
        begin
            if (v > {12'h000, `LIE_DLY_MAX}) begin
                clamp = `LIE_DLY_MAX;
            end else begin
                clamp = v[19:0];
            end
        end
    endfunction

    // two-flop synchronisers, then edge history
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
            sync_d <= 5'h00;
        end else begin
            sync_a <= {prot_trip, couple_off_pin, couple_on_pin,
                       inhibit_pin};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    // 1 ms tick divider
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (tick_cnt == TICK_CYC - 1) begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick <= 1'b0;
        end
    end

    // next commanded state from writes, coupling and pins
    reg [1:0] next_cmd;
    reg coup_hit;
    reg coup_val;
    always @* begin
        next_cmd = cmd_state;
        coup_hit = 1'b0;
        coup_val = 1'b0;
        if (wr_ctrl) begin
            next_cmd = (cmd_state & ~wen) | (wdat & wen);
            // a write to any coupled member drives the whole set
            if (wen[1] & couple_set[1]) begin
                coup_hit = 1'b1;
                coup_val = wdat[1];
            end
            if (wen[0] & couple_set[0]) begin
                coup_hit = 1'b1;
                coup_val = wdat[0];
            end
            if (coup_hit) begin
                next_cmd = coup_val ? (next_cmd | couple_set)
                                    : (next_cmd & ~couple_set);
            end
        end
        if (con_rise) begin
            next_cmd = next_cmd | couple_set;
        end
        if (coff_rise) begin
            next_cmd = next_cmd & ~couple_set;
        end
        if (wr_couple) begin
            next_cmd = 2'h0;
        end
    end

    // recalled state for an instrument reset
    wire [3:0] pon_idx = pon_sel - 4'h1;
    wire pon_slot = (pon_sel != `LIE_PON_DEFAULTS) &&
                    slot_valid[pon_idx];
    wire [1:0] rcl_state = pon_slot ? slot_state[pon_idx] : 2'h0;

    // configuration and commanded state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_state <= `LIE_RST_STATE;
            couple_set <= `LIE_RST_COUPLE;
            inh_mode <= `LIE_INH_OFF;
            pon_sel <= `LIE_PON_DEFAULTS;
            paired_parallel_mode <= 2'h0;
        end else if (soft_rst) begin
            // couple, inhibit mode and pon select are kept
            cmd_state <= rcl_state;
            paired_parallel_mode <= 2'h0;
        end else begin
            cmd_state <= next_cmd;
            if (wr_couple) begin
                couple_set <= pwdata[1:0];
            end
            if (wr & hit(paddr, `LIE_OFF_INHMODE)) begin
                if (pwdata[1:0] != 2'h3) begin
                    inh_mode <= pwdata[1:0];
                end
            end
            if (wr & hit(paddr, `LIE_OFF_PON)) begin
                if (pwdata[3:0] <= `LIE_PON_LAST) begin
                    pon_sel <= pwdata[3:0];
                end
            end
            if (wr & hit(paddr, `LIE_OFF_PAIR)) begin
                paired_parallel_mode <= {1'b0, pwdata[0]};
            end
        end
    end

    // saved state slots
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_valid <= {`LIE_SLOTS{1'b0}};
        end else if (save_req && save_slot < `LIE_SLOTS) begin
            slot_valid[save_slot] <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (save_req && save_slot < `LIE_SLOTS) begin
            slot_state[save_slot] <= cmd_state;
        end
    end

    // delay registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fall_dly[0] <= `LIE_RST_DELAY;
            fall_dly[1] <= `LIE_RST_DELAY;
            rise_dly[0] <= `LIE_RST_DELAY;
            rise_dly[1] <= `LIE_RST_DELAY;
        end else if (soft_rst) begin
            fall_dly[0] <= `LIE_RST_DELAY;
            fall_dly[1] <= `LIE_RST_DELAY;
            rise_dly[0] <= `LIE_RST_DELAY;
            rise_dly[1] <= `LIE_RST_DELAY;
        end else if (wr) begin
            if (hit(paddr, `LIE_OFF_FALL0)) begin
                fall_dly[0] <= clamp(pwdata);
            end
            if (hit(paddr, `LIE_OFF_FALL1)) begin
                fall_dly[1] <= clamp(pwdata);
            end
            if (hit(paddr, `LIE_OFF_RISE0)) begin
                rise_dly[0] <= clamp(pwdata);
            end
            if (hit(paddr, `LIE_OFF_RISE1)) begin
                rise_dly[1] <= clamp(pwdata);
            end
        end
    end

    // protection and inhibit latches; a set beats a clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prot_lat <= 2'h0;
            inh_lat <= 1'b0;
        end else begin
            prot_lat <= (prot_lat & ~clr_req) | prot_s;
            if (inh_mode == `LIE_INH_LATCH && inh_rise) begin
                inh_lat <= 1'b1;
            end else if (|clr_req && !inh_s) begin
                inh_lat <= 1'b0;
            end else if (inh_mode != `LIE_INH_LATCH) begin
                inh_lat <= 1'b0;
            end
        end
    end

    // inhibit gate shared by all channels
    reg inh_block;
    always @* begin
        case (inh_mode)
            `LIE_INH_LIVE: inh_block = inh_s;
            `LIE_INH_LATCH: inh_block = inh_lat | inh_rise;
            default: inh_block = 1'b0;
        endcase
    end

    // per-channel sequencer
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            reg [19:0] cnt;
            reg dir;
            // forced off: protection or inhibit, never delayed
            wire forced = prot_lat[g] | prot_s[g] | inh_block;
            // inhibit only matters when commanded on
            wire want = cmd_state[g] & ~forced;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    input_enable[g] <= 1'b0;
                    pend[g] <= 1'b0;
                    dir <= 1'b0;
                    cnt <= 20'h00000;
                end else if (soft_rst) begin
                    input_enable[g] <= 1'b0;
                    pend[g] <= 1'b0;
                    cnt <= 20'h00000;
                end else if (wr_couple) begin
                    // a coupling write cuts at once, no fall delay
                    input_enable[g] <= 1'b0;
                    pend[g] <= 1'b0;
                    cnt <= 20'h00000;
                end else if (input_enable[g] & forced) begin
                    input_enable[g] <= 1'b0;
                    pend[g] <= 1'b0;
                    cnt <= 20'h00000;
                end else if (want == input_enable[g]) begin
                    pend[g] <= 1'b0;
                    cnt <= 20'h00000;
                end else if (!pend[g] || dir != want) begin
                    // start or restart toward the new state
                    pend[g] <= 1'b1;
                    dir <= want;
                    cnt <= want ? rise_dly[g] : fall_dly[g];
                end else if (cnt == 20'h00000) begin
                    input_enable[g] <= dir;
                    pend[g] <= 1'b0;
                end else if (tick) begin
                    cnt <= cnt - 20'h00001;
                end
            end
        end
    endgenerate

    // read mux
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h00000000;
        case (paddr)
            `LIE_OFF_CTRL: rdata[1:0] = cmd_state;
            `LIE_OFF_COUPLE: rdata[1:0] = couple_set;
            `LIE_OFF_INHMODE: rdata[1:0] = inh_mode;
            `LIE_OFF_FALL0: rdata[19:0] = fall_dly[0];
            `LIE_OFF_FALL1: rdata[19:0] = fall_dly[1];
            `LIE_OFF_RISE0: rdata[19:0] = rise_dly[0];
            `LIE_OFF_RISE1: rdata[19:0] = rise_dly[1];
            `LIE_OFF_PON: rdata[3:0] = pon_sel;
            `LIE_OFF_PAIR: rdata[0] = paired_parallel_mode[0];
            `LIE_OFF_STATUS: begin
                rdata[`LIE_ST_EN_POS+1:`LIE_ST_EN_POS] = input_enable;
                rdata[`LIE_ST_PROT_POS+1:`LIE_ST_PROT_POS] = prot_lat;
                rdata[`LIE_ST_INH_POS] = inh_lat;
                rdata[`LIE_ST_INH_POS+1] = inh_s;
                rdata[`LIE_ST_PEND_POS+1:`LIE_ST_PEND_POS] = pend;
            end
            default: rdata = 32'h00000000;
        endcase
    end

    // apb answer: ready one cycle after setup, no waits beyond
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~mapped(paddr);
            prdata <= pwrite ? 32'h00000000 : rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** test/lie_pins.sv ***
// pin model for the inhibit, couple and protection inputs
`timescale 1ns/100ps
`default_nettype none
module lie_pins (
    // clock
    input wire logic clk,
    // requested levels {trip[1:0], couple off, couple on, inhibit}
    input wire logic [4:0] req,
    // pins toward the sequencer
    output var logic inhibit_pin,
    output var logic couple_on_pin,
    output var logic couple_off_pin,
    output var logic [1:0] prot_trip
);
    // pins start low and follow the request one edge later
    initial begin
        {prot_trip, couple_off_pin, couple_on_pin, inhibit_pin} = 5'h00;
    end
    always @(posedge clk) begin
        {prot_trip, couple_off_pin, couple_on_pin, inhibit_pin} <= req;
    end
endmodule
`default_nettype wire

// *** test/lie_sequencer_chk.sv ***
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "lie_defs.vh"
module lie_sequencer_chk #(
    parameter TICK_CYC = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and load side
    input wire logic inhibit_pin,
    input wire logic couple_on_pin,
    input wire logic couple_off_pin,
    input wire logic [1:0] prot_trip,
    input wire logic [1:0] input_enable,
    input wire logic [1:0] paired_parallel_mode
);
    logic wr;
    logic [1:0] mode;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // completed write strobe
    assign wr = psel && penable && pready && pwrite;
    // shadow of the inhibit mode, code 3 is ignored
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= 2'h0;
        end else if (wr && paddr == `LIE_OFF_INHMODE &&
                     pwdata[1:0] != 2'h3) begin
            mode <= pwdata[1:0];
        end
    end
    rst_off_a: assert property ($fell(rst) |-> input_enable == 2'h0)
        else $error("input on after reset");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdy_ans_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    bad_addr_a: assert property (psel && !penable && paddr > 8'h28 |=> pslverr)
        else $error("unmapped access not refused");
    cpl_off_a: assert property (wr && paddr == `LIE_OFF_COUPLE
        |-> ##[1:3] input_enable == 2'h0)
        else $error("coupling write left an input on");
    trip_off_a: assert property (prot_trip[0]
        |-> ##[1:4] !input_enable[0])
        else $error("trip did not cut the input");
    trip_hold_a: assert property ($rose(input_enable[0])
        |-> !prot_trip[0])
        else $error("input rose during trip");
    inh_drop_a: assert property (mode != 2'h0 && $rose(inhibit_pin)
        |-> ##[1:6] input_enable == 2'h0)
        else $error("inhibit did not cut the inputs");
    inh_ign_a: assert property (mode == 2'h0 && $rose(inhibit_pin) &&
        input_enable == 2'h3 |=> input_enable == 2'h3 [*4])
        else $error("inhibit acted while ignored");
    cover property (wr && paddr == `LIE_OFF_COUPLE);
    cover property ($rose(input_enable[1]));
    cover property (mode == 2'h2 && $rose(inhibit_pin));
endmodule
bind lie_sequencer lie_sequencer_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inhibit_pin(inhibit_pin),
    .couple_on_pin(couple_on_pin), .couple_off_pin(couple_off_pin),
    .prot_trip(prot_trip), .input_enable(input_enable),
    .paired_parallel_mode(paired_parallel_mode));
`default_nettype wire

// *** test/tb_lie_sequencer.sv ***
// register and pin sequences for the input enable sequencer
`timescale 1ns/100ps
`default_nettype none
`include "lie_defs.vh"
module tb_lie_sequencer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic inhibit_pin, couple_on_pin, couple_off_pin;
    logic [1:0] prot_trip, input_enable, paired_parallel_mode;
    logic [4:0] req = 5'h00;
    int fails = 0;
    int cmp_count = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    // device under test with a 4-cycle millisecond
    lie_sequencer #(.TICK_CYC(4)) u_lie_sequencer (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inhibit_pin(inhibit_pin),
        .couple_on_pin(couple_on_pin), .couple_off_pin(couple_off_pin),
        .prot_trip(prot_trip), .input_enable(input_enable),
        .paired_parallel_mode(paired_parallel_mode));
    // external pins
    lie_pins u_lie_pins (.clk(clk), .req(req), .inhibit_pin(inhibit_pin),
        .couple_on_pin(couple_on_pin), .couple_off_pin(couple_off_pin),
        .prot_trip(prot_trip));
    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic we,
            input logic [31:0] d);
        // an idle edge keeps a release and the next setup apart
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // comparisons
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic ce(input logic [1:0] e);
        chk({30'h0, input_enable}, {30'h0, e});
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #40000;
        fails++;
        report_and_stop;
    end
    // main sequence
    initial begin
        cyc(8);
        rst <= 1'b0;
        cyc(1);
        r(`LIE_OFF_CTRL, 0);
        r(`LIE_OFF_FALL0, 0);
        r(`LIE_OFF_RISE1, 0);
        r(`LIE_OFF_PAIR, 0);
        xfer(8'h2c, 1'b0, 32'h0);
        chk({31'h0, err}, 1);
        w(`LIE_OFF_FALL1, 32'hf9c19);
        r(`LIE_OFF_FALL1, 32'hf9c18);
        w(`LIE_OFF_FALL1, 0);
        w(`LIE_OFF_RISE0, 3);
        w(`LIE_OFF_FALL0, 2);
        w(`LIE_OFF_CTRL, 32'h101);
        cyc(4);
        ce(2'h0);
        cyc(20);
        ce(2'h1);
        w(`LIE_OFF_CTRL, 32'h100);
        cyc(2);
        ce(2'h1);
        cyc(20);
        ce(2'h0);
        w(`LIE_OFF_CTRL, 32'h101);
        cyc(24);
        req <= 5'h08;
        cyc(5);
        ce(2'h0);
        req <= 5'h00;
        cyc(10);
        ce(2'h0);
        r(`LIE_OFF_STATUS, 32'h4);
        w(`LIE_OFF_CMD, 1);
        cyc(4);
        ce(2'h0);
        cyc(20);
        ce(2'h1);
        w(`LIE_OFF_COUPLE, 3);
        cyc(3);
        ce(2'h0);
        r(`LIE_OFF_COUPLE, 3);
        w(`LIE_OFF_CTRL, 32'h101);
        cyc(24);
        ce(2'h3);
        req <= 5'h04;
        cyc(2);
        req <= 5'h00;
        cyc(24);
        ce(2'h0);
        req <= 5'h02;
        cyc(2);
        req <= 5'h00;
        cyc(24);
        ce(2'h3);
        w(`LIE_OFF_COUPLE, 2);
        r(`LIE_OFF_COUPLE, 2);
        ce(2'h0);
        w(`LIE_OFF_INHMODE, 1);
        w(`LIE_OFF_CMD, 4);
        r(`LIE_OFF_COUPLE, 2);
        r(`LIE_OFF_INHMODE, 1);
        w(`LIE_OFF_CTRL, 32'h303);
        cyc(24);
        req <= 5'h01;
        cyc(8);
        ce(2'h0);
        req <= 5'h00;
        cyc(24);
        ce(2'h3);
        w(`LIE_OFF_INHMODE, 2);
        req <= 5'h01;
        cyc(8);
        req <= 5'h00;
        cyc(30);
        ce(2'h0);
        w(`LIE_OFF_CMD, 1);
        cyc(24);
        ce(2'h3);
        w(`LIE_OFF_INHMODE, 0);
        req <= 5'h01;
        cyc(8);
        ce(2'h3);
        req <= 5'h00;
        w(`LIE_OFF_CMD, 32'h98);
        w(`LIE_OFF_PON, 32'ha);
        w(`LIE_OFF_PON, 32'hb);
        r(`LIE_OFF_PON, 32'ha);
        w(`LIE_OFF_CTRL, 32'h300);
        w(`LIE_OFF_CMD, 4);
        r(`LIE_OFF_CTRL, 3);
        w(`LIE_OFF_PON, 0);
        w(`LIE_OFF_CMD, 4);
        r(`LIE_OFF_CTRL, 0);
        // paired mode set once coupling is cleared; instrument reset clears it
        w(`LIE_OFF_COUPLE, 0);
        w(`LIE_OFF_PAIR, 1);
        r(`LIE_OFF_PAIR, 1);
        chk({30'h0, paired_parallel_mode}, 32'h1);
        w(`LIE_OFF_CMD, 4);
        r(`LIE_OFF_PAIR, 0);
        chk({30'h0, paired_parallel_mode}, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
